// [hw/lcdf_pkg.sv]
//==========================================================================
// Behaviour
// - 128 Hz clock: codes 1..14 give 32/16, 21.3/10.6, 16/8 Hz (2x); 32/10.7, 32/8 (3x, 4x)
// - 128 Hz clock: code 15 gives 128 Hz wave, code 0 gives 64 Hz wave
// - high enable bits 7..2 make segment pins 25..20 LCD (1) or GPIO (0), reset 0
// - low enable bits 3..0 make segment pins 19..16 LCD (1) or GPIO (0), reset 0
// - pointer write with bit 7 set copies the data byte into segment memory
// - pointer bits 5..4 choose the screen; pointer bit 6 reads zero
// - pointer bits 3..0 give the byte address within the screen
// - data register holds the byte to write or the byte last fetched
// - after reset the two shared pins act as segment lines 28 and 27
// - multiplex field 10 turns segment pin 28 into common line 2
// - multiplex field 11 turns pin 28 into common 2 and pin 27 into common 3
// - segment pins 0..15 are LCD segment drivers at all times except in reset and the first cycle after it
// - shared pin 27 becomes common line 3 only together with pin 28 as common line 2, never alone
// - setting configuration bit 6 clears all segment memory to zero
// - reset clears every byte of every screen to zero
// - configuration bit 3 selects 2048 Hz (0) or 128 Hz (1) table
// - each pointer write starts a read or write on the chosen screen and byte
// - each screen holds fifteen bytes, even segment low nibble, odd high nibble
//==========================================================================
package lcdf_pkg;

  // bus geometry
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = ADDR_W - 2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONFIG     = 10'h095;
  localparam logic [IDX_W-1:0] IDX_CLOCK      = 10'h096;
  localparam logic [IDX_W-1:0] IDX_SEG_HIGH   = 10'h097;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h098;
  localparam logic [IDX_W-1:0] IDX_POINTER    = 10'h0AC;
  localparam logic [IDX_W-1:0] IDX_DATA       = 10'h0AE;
  localparam logic [IDX_W-1:0] IDX_SEG_LOW    = 10'h0ED;

  // writable bit masks, reset value
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [7:0]  MASK_CONFIG    = 8'hBF;
  localparam logic [7:0]  MASK_CLOCK     = 8'hFF;
  localparam logic [7:0]  MASK_SEG_HIGH  = 8'hFC;
  localparam logic [7:0]  MASK_SEG_LOW   = 8'h0F;
  localparam logic [7:0]  MASK_POINTER   = 8'hBF;

  // configuration fields
  localparam int          CFG_CLEAR_BIT  = 6;
  localparam int          CFG_LCD_CLOCK_SELECT_BIT_BIT = 3;
  localparam int          CFG_BIAS_BIT   = 2;
  localparam int          CFG_MUX_LSB    = 0;
  localparam logic [1:0]  MUX_2X         = 2'h1;
  localparam logic [1:0]  MUX_3X         = 2'h2;
  localparam logic [1:0]  MUX_4X         = 2'h3;
  localparam int          CLK_CODE_LSB   = 0;

  // pointer fields
  localparam int          PTR_WRITE_BIT  = 7;
  localparam int          PTR_SCREEN_LSB = 4;
  localparam int          PTR_ADDR_LSB   = 0;
  localparam int          SCREEN_W       = 2;
  localparam int          BYTE_ADDR_W    = 4;
  localparam int          SCREENS        = 4;
  localparam int          SCREEN_BYTES   = 15;

  // segment pin layout
  localparam int          SEG_PINS       = 26;
  localparam int          SEG_FIXED      = 16;
  localparam int          SEG_HIGH_LSB   = 2;
  localparam int          SEG_HIGH_PINS  = 6;
  localparam int          SEG_LOW_PINS   = 4;

  // frame codes
  localparam logic [3:0]  CODE_ZERO      = 4'h0;
  localparam logic [3:0]  CODE_ONE       = 4'h1;
  localparam logic [3:0]  CODE_TWO       = 4'h2;
  localparam logic [3:0]  CODE_TOP       = 4'hF;

  // frequencies in tenths of a hertz
  localparam int          FREQ_W         = 11;
  localparam logic [FREQ_W-1:0] FREQ_128_0 = 11'h500;
  localparam logic [FREQ_W-1:0] FREQ_64_0  = 11'h280;
  localparam logic [FREQ_W-1:0] FREQ_42_7  = 11'h1AB;
  localparam logic [FREQ_W-1:0] FREQ_32_0  = 11'h140;
  localparam logic [FREQ_W-1:0] FREQ_21_3  = 11'h0D5;
  localparam logic [FREQ_W-1:0] FREQ_16_0  = 11'h0A0;
  localparam logic [FREQ_W-1:0] FREQ_10_7  = 11'h06B;
  localparam logic [FREQ_W-1:0] FREQ_10_6  = 11'h06A;
  localparam logic [FREQ_W-1:0] FREQ_8_0   = 11'h050;

  // status register fields
  localparam int          STAT_WAVE_LSB  = 0;
  localparam int          STAT_FRAME_LSB = 16;
  localparam int          STAT_VALID_BIT = 31;

endpackage : lcdf_pkg

// [hw/lcdf_seg_mem.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// segment memory: four screens of fifteen bytes
//==========================================================================
module lcdf_seg_mem
  import lcdf_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // bulk clear
  input  wire logic                        clear,
  // processor port
  input  wire logic                        wr_en,
  input  wire logic [lcdf_pkg::SCREEN_W-1:0]    cpu_screen,
  input  wire logic [lcdf_pkg::BYTE_ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]                  wr_data,
  output logic      [7:0]                  rd_data,
  // display scan port
  input  wire logic [lcdf_pkg::SCREEN_W-1:0]    disp_screen,
  input  wire logic [lcdf_pkg::BYTE_ADDR_W-1:0] disp_addr,
  output logic      [7:0]                  disp_data
);

  typedef struct packed {
    logic [SCREENS-1:0][SCREEN_BYTES-1:0][7:0] mem;
    logic [7:0]                                disp_data;
  } lcdf_mem_state_type;

  lcdf_mem_state_type s;
  lcdf_mem_state_type next_s;

  // out of range bytes read as zero
  function automatic logic [7:0] fetch(input lcdf_mem_state_type st,
                                       input logic [SCREEN_W-1:0] scr,
                                       input logic [BYTE_ADDR_W-1:0] adr);
    fetch = RESET_BYTE;
    if (32'(adr) < SCREEN_BYTES) begin
      fetch = st.mem[scr][adr];
    end
  endfunction : fetch

  assign rd_data   = fetch(s, cpu_screen, cpu_addr);
  assign disp_data = s.disp_data;

  // next state: clear wins over a write in the same cycle
  always_comb begin
    next_s           = s;
    next_s.disp_data = fetch(s, disp_screen, disp_addr);
    if (clear) begin
      next_s.mem = '0;
    end else if (wr_en && 32'(cpu_addr) < SCREEN_BYTES) begin
      next_s.mem[cpu_screen][cpu_addr] = wr_data;
    end
  end

  // state register, reset empties every screen
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : lcdf_seg_mem
`default_nettype wire

// [hw/lcdf_top.sv]
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// segment lcd frame decode, pin select and memory access
//==========================================================================
module lcdf_top
  import lcdf_pkg::*;
(
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          SRST,
  // axi4-lite write address
  input  wire logic [lcdf_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [lcdf_pkg::DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  // axi4-lite write response
  output logic      [1:0]                    S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [lcdf_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  // axi4-lite read data
  output logic      [lcdf_pkg::DATA_W-1:0]   S_AXI_RDATA,
  output logic      [1:0]                    S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  // display scan port
  input  wire logic [lcdf_pkg::SCREEN_W-1:0]    DISP_SCREEN,
  input  wire logic [lcdf_pkg::BYTE_ADDR_W-1:0] DISP_ADDR,
  output logic      [7:0]                    DISP_DATA,
  // pin function selects
  output logic      [lcdf_pkg::SEG_PINS-1:0] SEG_LCD_SELECT,
  output logic                               SEG27_IS_COMMON_LINE_3,
  output logic                               SEG28_IS_COMMON_LINE_2,
  // timing configuration
  output logic                               LCD_CLOCK_SELECT,
  output logic                               LCD_BIAS,
  output logic      [lcdf_pkg::FREQ_W-1:0]   WAVE_FREQ_TENTHS,
  output logic      [lcdf_pkg::FREQ_W-1:0]   FRAME_FREQ_TENTHS,
  output logic                               FREQ_VALID
);

  typedef struct packed {
    logic                     aw_held;
    logic [IDX_W-1:0]         aw_index;
    logic                     w_held;
    logic [7:0]               w_byte;
    logic                     w_lane0;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [DATA_W-1:0]        rdata;
    logic [1:0]               rresp;
    logic [7:0]               lcd_configuration_register;
    logic [7:0]               lcd_clock_register;
    logic [7:0]               lcd_segment_enable_high;
    logic [7:0]               lcd_segment_enable_low;
    logic [7:0]               lcd_memory_pointer;
    logic [7:0]               lcd_memory_data;
    logic [SEG_PINS-1:0]      seg_select;
    logic                     seg27_common;
    logic                     seg28_common;
    logic [FREQ_W-1:0]        wave_freq;
    logic [FREQ_W-1:0]        frame_freq;
    logic                     freq_valid;
  } lcdf_state_type;

  lcdf_state_type s;
  lcdf_state_type next_s;

  logic       write_do;
  logic       ptr_write;
  logic       mem_wr_en;
  logic       mem_clear;
  logic [7:0] mem_rd_data;
  logic [IDX_W-1:0] rd_index;

  //==========================================================================
  // helper functions
  //==========================================================================

  // word index of a byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[ADDR_W-1:2];
  endfunction : reg_index

  // true for any register this block answers
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx == IDX_CONFIG) || (idx == IDX_CLOCK) || (idx == IDX_SEG_HIGH) ||
                (idx == IDX_STATUS) || (idx == IDX_POINTER) || (idx == IDX_DATA) ||
                (idx == IDX_SEG_LOW);
  endfunction : is_mapped

  // waveform frequency for the slow clock table
  function automatic logic [FREQ_W-1:0] wave_of(input logic [3:0] code,
                                                 input logic [1:0] mux);
    if (code == CODE_TOP) begin
      wave_of = FREQ_128_0;
    end else if (code == CODE_ZERO) begin
      wave_of = FREQ_64_0;
    end else if (mux != MUX_2X) begin
      wave_of = FREQ_32_0;
    end else if (code == CODE_ONE) begin
      wave_of = FREQ_32_0;
    end else if (code == CODE_TWO) begin
      wave_of = FREQ_21_3;
    end else begin
      wave_of = FREQ_16_0;
    end
  endfunction : wave_of

  // frame frequency for the slow clock table
  function automatic logic [FREQ_W-1:0] frame_of(input logic [3:0] code,
                                                  input logic [1:0] mux);
    frame_of = FREQ_8_0;
    case (mux)
      MUX_3X: begin
        if (code == CODE_TOP) frame_of = FREQ_42_7;
        else if (code == CODE_ZERO) frame_of = FREQ_21_3;
        else frame_of = FREQ_10_7;
      end
      MUX_4X: begin
        if (code == CODE_TOP) frame_of = FREQ_32_0;
        else if (code == CODE_ZERO) frame_of = FREQ_16_0;
        else frame_of = FREQ_8_0;
      end
      default: begin
        if (code == CODE_TOP) frame_of = FREQ_64_0;
        else if (code == CODE_ZERO) frame_of = FREQ_32_0;
        else if (code == CODE_ONE) frame_of = FREQ_16_0;
        else if (code == CODE_TWO) frame_of = FREQ_10_6;
        else frame_of = FREQ_8_0;
      end
    endcase
  endfunction : frame_of

  //==========================================================================
  // bus handshakes and memory strobes
  //==========================================================================

  // ready while the slot is free and no response is pending
  assign S_AXI_AWREADY = !s.aw_held && !s.bvalid;
  assign S_AXI_WREADY  = !s.w_held && !s.bvalid;
  assign S_AXI_ARREADY = !s.rvalid;
  assign S_AXI_BVALID  = s.bvalid;
  assign S_AXI_BRESP   = s.bresp;
  assign S_AXI_RVALID  = s.rvalid;
  assign S_AXI_RDATA   = s.rdata;
  assign S_AXI_RRESP   = s.rresp;

  // a write is carried out once address and data are both held and byte lane 0 is strobed
  assign write_do  = s.aw_held && s.w_held && s.w_lane0;
  assign ptr_write = write_do && (s.aw_index == IDX_POINTER);
  assign mem_wr_en = ptr_write && s.w_byte[PTR_WRITE_BIT];
  assign mem_clear = write_do && (s.aw_index == IDX_CONFIG) &&
                     s.w_byte[CFG_CLEAR_BIT];
  assign rd_index  = reg_index(S_AXI_ARADDR);

  //==========================================================================
  // segment memory
  //==========================================================================

  lcdf_seg_mem u_seg_mem (
    .clk         (CLK),
    .srst        (SRST),
    .clear       (mem_clear),
    .wr_en       (mem_wr_en),
    .cpu_screen  (s.w_byte[PTR_SCREEN_LSB +: SCREEN_W]),
    .cpu_addr    (s.w_byte[PTR_ADDR_LSB +: BYTE_ADDR_W]),
    .wr_data     (s.lcd_memory_data),
    .rd_data     (mem_rd_data),
    .disp_screen (DISP_SCREEN),
    .disp_addr   (DISP_ADDR),
    .disp_data   (DISP_DATA)
  );

  //==========================================================================
  // next state
  //==========================================================================

  always_comb begin
    next_s = s;

    // capture address and data in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_s.aw_held  = 1'b1;
      next_s.aw_index = reg_index(S_AXI_AWADDR);
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_s.w_held  = 1'b1;
      next_s.w_byte  = S_AXI_WDATA[7:0];
      next_s.w_lane0 = S_AXI_WSTRB[0];
    end

    // complete the write and raise the response
    if (s.aw_held && s.w_held) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = is_mapped(s.aw_index) ? RESP_OKAY : RESP_SLVERR;
      if (write_do) begin
        case (s.aw_index)
          IDX_CONFIG:   next_s.lcd_configuration_register = s.w_byte & MASK_CONFIG;
          IDX_CLOCK:    next_s.lcd_clock_register = s.w_byte & MASK_CLOCK;
          IDX_SEG_HIGH: next_s.lcd_segment_enable_high = s.w_byte & MASK_SEG_HIGH;
          IDX_SEG_LOW:  next_s.lcd_segment_enable_low = s.w_byte & MASK_SEG_LOW;
          IDX_POINTER:  next_s.lcd_memory_pointer = s.w_byte & MASK_POINTER;
          IDX_DATA:     next_s.lcd_memory_data = s.w_byte;
          default:      next_s.lcd_memory_data = s.lcd_memory_data;
        endcase
        // a pointer read fetches the addressed byte into the data register
        if (ptr_write && !s.w_byte[PTR_WRITE_BIT]) begin
          next_s.lcd_memory_data = mem_rd_data;
        end
      end
    end else if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // reads answer one cycle after the address is taken
    if (S_AXI_ARVALID && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = is_mapped(rd_index) ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata  = '0;
      case (rd_index)
        IDX_CONFIG:   next_s.rdata[7:0] = s.lcd_configuration_register;
        IDX_CLOCK:    next_s.rdata[7:0] = s.lcd_clock_register;
        IDX_SEG_HIGH: next_s.rdata[7:0] = s.lcd_segment_enable_high;
        IDX_SEG_LOW:  next_s.rdata[7:0] = s.lcd_segment_enable_low;
        IDX_POINTER:  next_s.rdata[7:0] = s.lcd_memory_pointer;
        IDX_DATA:     next_s.rdata[7:0] = s.lcd_memory_data;
        IDX_STATUS: begin
          next_s.rdata[STAT_WAVE_LSB +: FREQ_W]  = s.wave_freq;
          next_s.rdata[STAT_FRAME_LSB +: FREQ_W] = s.frame_freq;
          next_s.rdata[STAT_VALID_BIT]           = s.freq_valid;
        end
        default:      next_s.rdata = '0;
      endcase
    end else if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end

    // pin selects follow the enable and multiplex registers
    next_s.seg_select[SEG_FIXED-1:0] = '1;
    next_s.seg_select[SEG_FIXED +: SEG_LOW_PINS] =
      s.lcd_segment_enable_low[SEG_LOW_PINS-1:0];
    next_s.seg_select[SEG_FIXED+SEG_LOW_PINS +: SEG_HIGH_PINS] =
      s.lcd_segment_enable_high[SEG_HIGH_LSB +: SEG_HIGH_PINS];
    next_s.seg28_common =
      (s.lcd_configuration_register[CFG_MUX_LSB +: 2] == MUX_3X) ||
      (s.lcd_configuration_register[CFG_MUX_LSB +: 2] == MUX_4X);
    next_s.seg27_common =
      (s.lcd_configuration_register[CFG_MUX_LSB +: 2] == MUX_4X);

    // slow clock frame table, fast clock table is outside this block
    next_s.freq_valid = s.lcd_configuration_register[CFG_LCD_CLOCK_SELECT_BIT_BIT] &&
                        (s.lcd_configuration_register[CFG_MUX_LSB +: 2] != 2'h0);
    next_s.wave_freq  = '0;
    next_s.frame_freq = '0;
    if (next_s.freq_valid) begin
      next_s.wave_freq  = wave_of(s.lcd_clock_register[CLK_CODE_LSB +: 4],
                                  s.lcd_configuration_register[CFG_MUX_LSB +: 2]);
      next_s.frame_freq = frame_of(s.lcd_clock_register[CLK_CODE_LSB +: 4],
                                   s.lcd_configuration_register[CFG_MUX_LSB +: 2]);
    end
  end

  //==========================================================================
  // state register
  //==========================================================================

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state
  assign SEG_LCD_SELECT         = s.seg_select;
  assign SEG27_IS_COMMON_LINE_3 = s.seg27_common;
  assign SEG28_IS_COMMON_LINE_2 = s.seg28_common;
  assign LCD_CLOCK_SELECT       = s.lcd_configuration_register[CFG_LCD_CLOCK_SELECT_BIT_BIT];
  assign LCD_BIAS               = s.lcd_configuration_register[CFG_BIAS_BIT];
  assign WAVE_FREQ_TENTHS       = s.wave_freq;
  assign FRAME_FREQ_TENTHS      = s.frame_freq;
  assign FREQ_VALID             = s.freq_valid;

endmodule : lcdf_top
`default_nettype wire

// [sim/lcdf_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// checker on the top ports
//==========================================================================
module lcdf_monitor
  import lcdf_pkg::*;
(
  // clock and reset
  input wire logic                        CLK,
  input wire logic                        SRST,
  // observed outputs
  input wire logic [7:0]                  DISP_DATA,
  input wire logic [lcdf_pkg::SEG_PINS-1:0] SEG_LCD_SELECT,
  input wire logic                        SEG27_IS_COMMON_LINE_3,
  input wire logic                        SEG28_IS_COMMON_LINE_2,
  input wire logic                        LCD_CLOCK_SELECT,
  input wire logic [lcdf_pkg::FREQ_W-1:0] WAVE_FREQ_TENTHS,
  input wire logic [lcdf_pkg::FREQ_W-1:0] FRAME_FREQ_TENTHS,
  input wire logic                        FREQ_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // pin selects and memory
  fixed_pins_a: assert property (!$past(SRST) |-> SEG_LCD_SELECT[15:0] == 16'hFFFF)
    else $error("fixed segment pins not lcd");
  en_reset_a: assert property (disable iff (1'b0) SRST |=> SEG_LCD_SELECT == 26'h0)
    else $error("shared pins not gpio after reset");
  mem_reset_a: assert property (disable iff (1'b0) SRST |=> DISP_DATA == 8'h00)
    else $error("segment memory not cleared by reset");
  com_pair_a: assert property (SEG27_IS_COMMON_LINE_3 |-> SEG28_IS_COMMON_LINE_2)
    else $error("common line 3 without common line 2");
  // frequency decode
  clock_gate_a: assert property (FREQ_VALID ? $past(LCD_CLOCK_SELECT) : WAVE_FREQ_TENTHS == 11'h000)
    else $error("frequency valid without slow clock");
  slow_frame_a: assert property (FREQ_VALID && WAVE_FREQ_TENTHS == FREQ_32_0 |->
    FRAME_FREQ_TENTHS == (SEG27_IS_COMMON_LINE_3 ? FREQ_8_0 : SEG28_IS_COMMON_LINE_2 ? FREQ_10_7 : FREQ_16_0))
    else $error("frame rate wrong for 32 Hz wave");
  fast_frame_a: assert property (FREQ_VALID && WAVE_FREQ_TENTHS == FREQ_128_0 |->
    FRAME_FREQ_TENTHS == (SEG27_IS_COMMON_LINE_3 ? FREQ_32_0 : SEG28_IS_COMMON_LINE_2 ? FREQ_42_7 : FREQ_64_0))
    else $error("frame rate wrong for 128 Hz wave");
  zero_code_a: assert property (FREQ_VALID && WAVE_FREQ_TENTHS == FREQ_64_0 |->
    FRAME_FREQ_TENTHS == (SEG27_IS_COMMON_LINE_3 ? FREQ_16_0 : SEG28_IS_COMMON_LINE_2 ? FREQ_21_3 : FREQ_32_0))
    else $error("frame rate wrong for 64 Hz wave");
endmodule : lcdf_monitor
`default_nettype wire

// [sim/lcdf_glass.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// glass model: scans every screen byte and keeps what it saw
//==========================================================================
module lcdf_glass (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // scan port
  output logic [1:0]      DISP_SCREEN,
  output logic [3:0]      DISP_ADDR,
  input wire logic [7:0]  DISP_DATA
);
  logic [5:0] pos = 6'h00;
  logic [5:0] prev = 6'h00;
  logic [7:0] img [64];
  assign DISP_SCREEN = pos[5:4];
  assign DISP_ADDR = pos[3:0];
  // data returns one cycle after its address
  always_ff @(posedge CLK) begin
    prev <= pos;
    pos <= SRST ? 6'h00 : pos + 6'h01;
    img[prev] <= DISP_DATA;
  end
endmodule : lcdf_glass
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// testbench
//==========================================================================
module testbench;
  import lcdf_pkg::*;
  localparam logic [11:0] A_CFG = 12'h254, A_CLK = 12'h258, A_SH = 12'h25C;
  localparam logic [11:0] A_PTR = 12'h2B0, A_DAT = 12'h2B8, A_SL = 12'h3B4;
  logic CLK = 1'b0, SRST = 1'b1;
  logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, SEG27_IS_COMMON_LINE_3;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, DISP_SCREEN, last_resp;
  logic [3:0] DISP_ADDR;
  logic [7:0] DISP_DATA;
  logic [25:0] SEG_LCD_SELECT;
  logic SEG28_IS_COMMON_LINE_2, LCD_CLOCK_SELECT, LCD_BIAS, FREQ_VALID;
  logic [10:0] WAVE_FREQ_TENTHS, FRAME_FREQ_TENTHS;
  logic [7:0] locs [4] = '{8'h00, 8'h3E, 8'h17, 8'h2F};
  logic [7:0] vals [4] = '{8'h5A, 8'hC3, 8'h96, 8'h3C};
  int err_count = 0, checks = 0;
  always #25 CLK = ~CLK;
  lcdf_top u_lcdf_top (.CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .DISP_SCREEN, .DISP_ADDR,
    .DISP_DATA, .SEG_LCD_SELECT, .SEG27_IS_COMMON_LINE_3, .SEG28_IS_COMMON_LINE_2,
    .LCD_CLOCK_SELECT, .LCD_BIAS, .WAVE_FREQ_TENTHS, .FRAME_FREQ_TENTHS, .FREQ_VALID);
  lcdf_glass u_lcdf_glass (.CLK, .SRST, .DISP_SCREEN, .DISP_ADDR, .DISP_DATA);
  // expected wave and frame for the slow clock
  function automatic logic [21:0] exp_f(input logic [1:0] m, input logic [3:0] c);
    if (c == 4'hF) return {FREQ_128_0, m == MUX_2X ? FREQ_64_0 : m == MUX_3X ? FREQ_42_7 : FREQ_32_0};
    if (c == 4'h0) return {FREQ_64_0, m == MUX_2X ? FREQ_32_0 : m == MUX_3X ? FREQ_21_3 : FREQ_16_0};
    if (m != MUX_2X) return {FREQ_32_0, m == MUX_3X ? FREQ_10_7 : FREQ_8_0};
    if (c == 4'h1) return {FREQ_32_0, FREQ_16_0};
    if (c == 4'h2) return {FREQ_21_3, FREQ_10_6};
    return {FREQ_16_0, FREQ_8_0};
  endfunction : exp_f
  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // bus cycles, each wait bounded
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, v};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    S_AXI_BREADY <= 1'b0;
    last_resp = S_AXI_BRESP;
    if (n == 40) chk(32'h0, 32'h1);
    if (n == 40) finish_test();
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    int n;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    S_AXI_RREADY <= 1'b0;
    last_resp = S_AXI_RRESP;
    chk(S_AXI_RDATA, e);
    if (n == 40) finish_test();
  endtask : rdchk
  // main sequence
  initial begin
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(32'(SEG_LCD_SELECT), 32'h0000FFFF);
    chk(32'({SEG27_IS_COMMON_LINE_3, SEG28_IS_COMMON_LINE_2}), 32'h0);
    foreach (locs[i]) rdchk(i == 3 ? A_SL : A_SH + 12'(i * 'h54), 32'h0);
    wr(A_SH, 8'hFF);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rdchk(A_SH, 32'hFC);
    wr(A_SL, 8'hFF);
    rdchk(A_SL, 32'h0F);
    wr(A_SH, 8'hD8);
    wr(A_SL, 8'h0A);
    repeat (2) @(posedge CLK);
    chk(32'(SEG_LCD_SELECT), 32'h036AFFFF);
    for (int m = 0; m < 4; m++) begin
      wr(A_CFG, {5'b00001, m[0], 2'(m)});
      for (int c = 0; c < 16; c++) begin
        wr(A_CLK, 8'(c));
        repeat (2) @(posedge CLK);
        chk(32'({FREQ_VALID, WAVE_FREQ_TENTHS, FRAME_FREQ_TENTHS}),
            32'(m == 0 ? 23'h0 : {1'b1, exp_f(2'(m), 4'(c))}));
      end
      chk(32'({SEG28_IS_COMMON_LINE_2, SEG27_IS_COMMON_LINE_3, LCD_BIAS}),
          32'({m >= 2, m == 3, m[0]}));
    end
    wr(A_CFG, 8'h03);
    repeat (2) @(posedge CLK);
    chk(32'({FREQ_VALID, LCD_CLOCK_SELECT}), 32'h0);
    foreach (locs[i]) begin
      wr(A_DAT, vals[i]);
      rdchk(A_DAT, 32'(vals[i]));
      wr(A_PTR, 8'hC0 | locs[i]);
      rdchk(A_PTR, 32'(8'h80 | locs[i]));
    end
    foreach (locs[i]) begin
      wr(A_PTR, locs[i]);
      rdchk(A_DAT, i == 3 ? 32'h0 : 32'(vals[i]));
    end
    repeat (70) @(posedge CLK);
    foreach (locs[i]) chk(32'(u_lcdf_glass.img[locs[i][5:0]]), i == 3 ? 32'h0 : 32'(vals[i]));
    wr(A_CFG, 8'h40);
    rdchk(A_CFG, 32'h0);
    wr(A_PTR, 8'h3E);
    rdchk(A_DAT, 32'h0);
    repeat (70) @(posedge CLK);
    chk(32'(u_lcdf_glass.img[6'h17]), 32'h0);
    wr(12'h004, 8'h00);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    rdchk(12'h004, 32'h0);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    finish_test();
  end
endmodule : testbench
bind lcdf_top lcdf_monitor u_lcdf_monitor (.CLK, .SRST, .DISP_DATA, .SEG_LCD_SELECT,
  .SEG27_IS_COMMON_LINE_3, .SEG28_IS_COMMON_LINE_2, .LCD_CLOCK_SELECT,
  .WAVE_FREQ_TENTHS, .FRAME_FREQ_TENTHS, .FREQ_VALID);
`default_nettype wire
